// ### afc_cfg.svh
// Constants for the converter output format and power control block
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define AFC_ADDR_W          12
`define AFC_ADDR_CTRL       12'h000
`define AFC_ADDR_STATUS     12'h004
`define AFC_ADDR_OVF_COUNT  12'h008

// Control fields
`define AFC_CTRL_LVL_LO     0
`define AFC_CTRL_LVL_HI     1
`define AFC_CTRL_PD         2
`define AFC_CTRL_OEN        3
`define AFC_CTRL_W          4
`define AFC_CTRL_RST        4'h8

// Status fields
`define AFC_STAT_MODE_LO    0
`define AFC_STAT_MODE_HI    1
`define AFC_STAT_TWOS       2
`define AFC_STAT_DCS        3
`define AFC_STAT_LOCKED     4
`define AFC_STAT_RECOVER    5
`define AFC_STAT_VALID      6
`define AFC_STAT_DRIVE      7

// ----------------------------------------------------------------------------
// Sample coding
// ----------------------------------------------------------------------------
`define AFC_DATA_W          12
`define AFC_CODE_MAX        12'hFFF
`define AFC_CODE_MIN        12'h000
`define AFC_OVF_CNT_W       16

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define AFC_CLK_PERIOD_NS   10
`define AFC_SLEEP_REC_NS    1000000
`define AFC_SLEEP_REC_CYC   ((`AFC_SLEEP_REC_NS + `AFC_CLK_PERIOD_NS - 1) / `AFC_CLK_PERIOD_NS)
`define AFC_NAP_REC_CYC     100
`define AFC_DCS_RELOCK_CYC  100
`define AFC_CLK_STOP_CYC    64
`define AFC_TMR_W           17

`endif

// ### afc_pkg.sv
// Types for the converter output format and power control block
`default_nettype none

package afc_pkg;

	typedef enum logic [1:0] {
		LVL_GND,
		LVL_THIRD,
		LVL_TWO_THIRDS,
		LVL_VDD
	} afc_level_t;

	typedef enum logic [1:0] {
		PWR_NORMAL,
		PWR_NAP,
		PWR_SLEEP
	} afc_pwr_mode_t;

endpackage : afc_pkg

`default_nettype wire

// ### afc_countdown.sv
// Loadable down counter used for recovery and relock intervals
`include "afc_cfg.svh"
`default_nettype none

module afc_countdown #(
	parameter int CNT_W = `AFC_TMR_W
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	input  wire logic             tick,
	output logic                  busy
);

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;

	assign count_d = load ? load_value :
	                 (tick && count_q != '0) ? count_q - 1'b1 : count_q;
	assign busy    = count_q != '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

endmodule : afc_countdown

`default_nettype wire

// ### afc_ctrl.sv
// Output coding, output enable and power mode control with APB registers
// Operation
// R1 - Ground or third level: offset binary
// R2 - Two-thirds or supply level: two's complement
// R3 - Stabilizer on only at middle levels
// R4 - Overflow flag high when out of range
// R5 - Output enable high tri-states all outputs
// R6 - Controller avoids toggling enable per sample
// R7 - Power-down low gives normal conversion
// R8 - Power-down and enable high give sleep
// R9 - Samples invalid for milliseconds after sleep
// R10 - Power-down high, enable low gives nap
// R11 - Nap recovery takes about 100 cycles
// R12 - Sleep and nap tri-state all outputs
// R13 - Capture ignores samples while invalid
// R14 - Twelve bits, MSB inverted, saturate on overflow
// R15 - Stabilizer relocks about 100 cycles
`include "afc_cfg.svh"
`default_nettype none

module afc_ctrl #(
	parameter int SLEEP_REC_CYCLES = `AFC_SLEEP_REC_CYC,
	parameter int NAP_REC_CYCLES   = `AFC_NAP_REC_CYC,
	parameter int RELOCK_CYCLES    = `AFC_DCS_RELOCK_CYC,
	parameter int CLK_STOP_CYCLES  = `AFC_CLK_STOP_CYC,
	parameter int TMR_W            = `AFC_TMR_W
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`AFC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   core_strobe,
	input  wire logic [`AFC_DATA_W-1:0] core_sample,
	input  wire logic                   core_over,
	input  wire logic                   core_under,
	output logic      [`AFC_DATA_W-1:0] sample_word,
	output logic                        sample_word_oe,
	output logic                        overflow_flag,
	output logic                        overflow_flag_oe,
	output logic                        sample_strobe,
	output logic                        data_valid,
	output logic                        dcs_enable,
	output var afc_pkg::afc_pwr_mode_t  power_mode
);

	import afc_pkg::*;

	// ------------------------------------------------------------------------
	// Coding function
	// ------------------------------------------------------------------------
	function automatic logic [`AFC_DATA_W-1:0] afc_code(
		input logic [`AFC_DATA_W-1:0] raw,
		input logic                   over,
		input logic                   under,
		input logic                   twos
	);
		logic [`AFC_DATA_W-1:0] ob;
		ob = over ? `AFC_CODE_MAX : (under ? `AFC_CODE_MIN : raw);
		afc_code = twos ? {~ob[`AFC_DATA_W-1], ob[`AFC_DATA_W-2:0]} : ob;
	endfunction : afc_code

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	afc_level_t                 level_q;
	logic                       pd_q;
	logic                       oen_q;
	logic [`AFC_OVF_CNT_W-1:0]  ovf_cnt_q;
	logic [`AFC_OVF_CNT_W-1:0]  ovf_cnt_d;
	logic [31:0]                prdata_q;
	logic                       pready_q;
	logic                       pslverr_q;
	logic [`AFC_DATA_W-1:0]     sample_word_q;
	logic                       sample_word_oe_q;
	logic                       overflow_flag_q;
	logic                       overflow_flag_oe_q;
	logic                       sample_strobe_q;
	logic                       data_valid_q;
	logic                       dcs_enable_q;
	afc_pwr_mode_t              mode_q;
	afc_pwr_mode_t              mode_d;
	logic [TMR_W-1:0]           gap_q;
	logic                       stopped_q;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire        setup_ph  = psel & ~penable;
	wire        access_ph = psel & penable & pready_q;
	wire        hit_ctrl  = paddr == `AFC_ADDR_CTRL;
	wire        hit_stat  = paddr == `AFC_ADDR_STATUS;
	wire        hit_ovf   = paddr == `AFC_ADDR_OVF_COUNT;
	wire        mapped    = hit_ctrl | hit_stat | hit_ovf;
	wire        ctrl_wr   = access_ph & pwrite & hit_ctrl;
	wire        ovf_clr   = access_ph & pwrite & hit_ovf;

	wire        twos_sel  = level_q == LVL_TWO_THIRDS || level_q == LVL_VDD; // see R2
	wire        rec_busy;
	wire        relock_busy;
	wire [31:0] ctrl_rd   = {28'h0000000, oen_q, pd_q, level_q};
	wire [31:0] stat_rd   = {24'h000000, sample_word_oe_q, data_valid_q, rec_busy,
	                         ~relock_busy, dcs_enable_q, twos_sel, mode_q};
	wire [31:0] ovf_rd    = {16'h0000, ovf_cnt_q};
	wire [31:0] rd_mux    = hit_ctrl ? ctrl_rd :
	                        hit_stat ? stat_rd :
	                        hit_ovf  ? ovf_rd  : 32'h00000000;

	// ------------------------------------------------------------------------
	// Format and mode decode
	// ------------------------------------------------------------------------
	wire        dcs_d     = level_q == LVL_THIRD || level_q == LVL_TWO_THIRDS; // see R3
	wire        normal_d  = mode_d == PWR_NORMAL;
	wire        drive_d   = normal_d & ~oen_q; // see R5, R12
	wire        take      = core_strobe & normal_d;
	wire        out_range = core_over | core_under; // see R4

	// Power mode from the power-down and enable bits
	assign mode_d = !pd_q ? PWR_NORMAL :          // see R7
	                oen_q ? PWR_SLEEP  :          // see R8
	                        PWR_NAP;              // see R10

	// ------------------------------------------------------------------------
	// Recovery after nap or sleep
	// ------------------------------------------------------------------------
	logic [TMR_W-1:0] rec_value;
	wire              rec_load = mode_q != PWR_NORMAL && normal_d;

	always_comb begin
		case (mode_q)
			PWR_SLEEP: rec_value = TMR_W'(SLEEP_REC_CYCLES); // see R9
			PWR_NAP:   rec_value = TMR_W'(NAP_REC_CYCLES);   // see R11
			default:   rec_value = '0;
		endcase
	end

	afc_countdown #(
		.CNT_W      (TMR_W)
	) u_rec_timer (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (rec_load),
		.load_value (rec_value),
		.tick       (1'b1),
		.busy       (rec_busy)
	);

	// ------------------------------------------------------------------------
	// Stabilizer relock after turn-on or a stopped clock
	// ------------------------------------------------------------------------
	wire dcs_rise    = dcs_d & ~dcs_enable_q;
	wire relock_load = dcs_d & (dcs_rise | (core_strobe & stopped_q)); // see R15
	wire gap_full    = gap_q == TMR_W'(CLK_STOP_CYCLES);

	afc_countdown #(
		.CNT_W      (TMR_W)
	) u_relock_timer (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (relock_load),
		.load_value (TMR_W'(RELOCK_CYCLES)),
		.tick       (core_strobe),
		.busy       (relock_busy)
	);

	// Samples count as valid only outside every recovery interval
	wire valid_d = normal_d & ~rec_busy & ~rec_load &
	               ~(dcs_d & (relock_busy | relock_load)); // see R9, R11, R15

	// Overflow event count, saturating; an event beats a clear
	wire ovf_event = take & out_range; // see R4
	wire ovf_full  = ovf_cnt_q == '1;
	assign ovf_cnt_d = ovf_event ? (ovf_full ? ovf_cnt_q : ovf_cnt_q + 1'b1) :
	                   ovf_clr   ? '0 : ovf_cnt_q;

	// ------------------------------------------------------------------------
	// Clocked state
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= LVL_GND;
			pd_q    <= 1'b0;
			oen_q   <= 1'b1;
		end else if (ctrl_wr) begin
			level_q <= afc_level_t'(pwdata[`AFC_CTRL_LVL_HI:`AFC_CTRL_LVL_LO]);
			pd_q    <= pwdata[`AFC_CTRL_PD];
			oen_q   <= pwdata[`AFC_CTRL_OEN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
			ovf_cnt_q <= '0;
		end else begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph & ~mapped;
			prdata_q  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
			ovf_cnt_q <= ovf_cnt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_word_q <= `AFC_CODE_MIN;
			overflow_flag_q <= 1'b0;
		end else if (take) begin
			sample_word_q   <= afc_code(core_sample, core_over, core_under, twos_sel); // see R1, R2, R14
			overflow_flag_q <= out_range; // see R4
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_word_oe_q   <= 1'b0;
			overflow_flag_oe_q <= 1'b0;
			sample_strobe_q    <= 1'b0;
			data_valid_q       <= 1'b0;
			dcs_enable_q       <= 1'b0;
			mode_q             <= PWR_NORMAL;
		end else begin
			sample_word_oe_q   <= drive_d;  // see R5, R12
			overflow_flag_oe_q <= drive_d;  // see R5, R12
			sample_strobe_q    <= take;
			data_valid_q       <= valid_d;
			dcs_enable_q       <= dcs_d;    // see R3
			mode_q             <= mode_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q     <= '0;
			stopped_q <= 1'b0;
		end else begin
			gap_q     <= core_strobe ? '0 : (gap_full ? gap_q : gap_q + 1'b1);
			stopped_q <= core_strobe ? 1'b0 : (stopped_q | gap_full);
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign sample_word      = sample_word_q;
	assign sample_word_oe   = sample_word_oe_q;
	assign overflow_flag    = overflow_flag_q;
	assign overflow_flag_oe = overflow_flag_oe_q;
	assign sample_strobe    = sample_strobe_q;
	assign data_valid       = data_valid_q;
	assign dcs_enable       = dcs_enable_q;
	assign power_mode       = mode_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_offset_format: assert property ( // see R1
		@(posedge pclk) disable iff (!presetn)
		take && !out_range && !twos_sel |=> sample_word_q == $past(core_sample)
	) else $error("offset binary word differs from core sample");

	a_twos_format: assert property ( // see R2
		@(posedge pclk) disable iff (!presetn)
		take && !out_range && twos_sel |=>
			sample_word_q == {~$past(core_sample[`AFC_DATA_W-1]),
			                  $past(core_sample[`AFC_DATA_W-2:0])}
	) else $error("two's complement word is not MSB-inverted sample");

	a_dcs_levels: assert property ( // see R3
		@(posedge pclk) disable iff (!presetn)
		(level_q == LVL_GND || level_q == LVL_VDD) ##1 $stable(level_q) |-> !dcs_enable_q
	) else $error("stabilizer enabled at an outer level");

	a_overflow_flag: assert property ( // see R4
		@(posedge pclk) disable iff (!presetn)
		take |=> overflow_flag_q == ($past(core_over) || $past(core_under))
	) else $error("overflow flag does not follow range");

	a_saturate_high: assert property ( // see R14
		@(posedge pclk) disable iff (!presetn)
		take && core_over |=> sample_word_q == ($past(twos_sel) ? 12'h7FF : `AFC_CODE_MAX)
	) else $error("over-range word not saturated");

	a_saturate_low: assert property ( // see R14
		@(posedge pclk) disable iff (!presetn)
		take && core_under && !core_over |=>
			sample_word_q == ($past(twos_sel) ? 12'h800 : `AFC_CODE_MIN)
	) else $error("under-range word not saturated");

	a_power_hiz: assert property ( // see R12
		@(posedge pclk) disable iff (!presetn)
		mode_q != PWR_NORMAL |-> !sample_word_oe_q && !overflow_flag_oe_q
	) else $error("outputs driven in nap or sleep");

	a_ovf_count: assert property ( // see R4
		@(posedge pclk) disable iff (!presetn)
		ovf_event && !ovf_full |=> ovf_cnt_q == $past(ovf_cnt_q) + 1'b1
	) else $error("overflow count missed an event");

	a_oe_hiz: assert property ( // see R5
		@(posedge pclk) disable iff (!presetn)
		oen_q |=> !sample_word_oe_q && !overflow_flag_oe_q
	) else $error("outputs driven while enable is high");

	a_sleep_entry: assert property ( // see R8
		@(posedge pclk) disable iff (!presetn)
		pd_q && oen_q |=> mode_q == PWR_SLEEP && !sample_word_oe_q
	) else $error("sleep not entered");

	a_nap_entry: assert property ( // see R10
		@(posedge pclk) disable iff (!presetn)
		pd_q && !oen_q |=> mode_q == PWR_NAP && !overflow_flag_oe_q
	) else $error("nap not entered or outputs driven");

	a_normal_run: assert property ( // see R7
		@(posedge pclk) disable iff (!presetn)
		!pd_q && !oen_q |=> mode_q == PWR_NORMAL && sample_word_oe_q
	) else $error("normal operation not driving outputs");

	a_sleep_invalid: assert property ( // see R9
		@(posedge pclk) disable iff (!presetn)
		mode_q == PWR_SLEEP && normal_d |=> !data_valid_q [*8]
	) else $error("data valid too soon after sleep");

	a_nap_recover: assert property ( // see R11
		@(posedge pclk) disable iff (!presetn)
		mode_q == PWR_NAP && normal_d && !dcs_d |=>
			!data_valid_q [*8] ##[1:100] (data_valid_q || pd_q || dcs_d)
	) else $error("nap recovery outside expected interval");

	a_apb_ready: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_ph |=> pready_q ##1 !pready_q
	) else $error("APB ready not a single access cycle");

endmodule : afc_ctrl

`default_nettype wire

// ### afc_capture_model.sv
// Capture logic model that takes coded samples from the converter pins
`default_nettype none

module afc_capture_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] word_pins,
	input  wire logic        flag_pin,
	input  wire logic        pins_driven,
	input  wire logic        sample_strobe,
	input  wire logic        data_valid,
	output logic      [15:0] taken_q,
	output logic      [12:0] last_q
);
	// ------------------------------------------------------------------
	// Keeps only driven, trustworthy samples
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken_q <= 16'h0000;
			last_q  <= 13'h0000;
		end else if (sample_strobe && data_valid && pins_driven) begin
			taken_q <= taken_q + 16'h0001;
			last_q  <= {flag_pin, word_pins};
		end
	end
endmodule : afc_capture_model

`default_nettype wire

// ### afc_ctrl_test.sv
// Self-checking testbench for the output format and power control block
`include "afc_cfg.svh"
`default_nettype none

module afc_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import afc_pkg::*;

	localparam int NAP_N   = 100;
	localparam int SLEEP_N = 20;
	localparam int RLK_N   = 100;

	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic          core_strobe, core_over, core_under, overflow_flag, flag_pin, flag_last;
	logic          sample_word_oe, overflow_flag_oe, sample_strobe, data_valid, dcs_enable;
	logic [11:0]   paddr, core_sample, sample_word, word_pins, bus_last, exp;
	logic [31:0]   pwdata, prdata, rd;
	logic [15:0]   taken, taken_mark;
	logic [12:0]   last_cap;
	afc_pwr_mode_t power_mode;
	int            bad_count, tests_run, n_ovf;

	afc_ctrl #(.SLEEP_REC_CYCLES(SLEEP_N), .NAP_REC_CYCLES(NAP_N)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_strobe(core_strobe),
		.core_sample(core_sample), .core_over(core_over), .core_under(core_under),
		.sample_word(sample_word), .sample_word_oe(sample_word_oe),
		.overflow_flag(overflow_flag), .overflow_flag_oe(overflow_flag_oe),
		.sample_strobe(sample_strobe), .data_valid(data_valid),
		.dcs_enable(dcs_enable), .power_mode(power_mode));

	afc_capture_model cap_u (
		.pclk(pclk), .presetn(presetn), .word_pins(word_pins), .flag_pin(flag_pin),
		.pins_driven(sample_word_oe), .sample_strobe(sample_strobe),
		.data_valid(data_valid), .taken_q(taken), .last_q(last_cap));

	// ------------------------------------------------------------------
	// Released pins show the inverse of their last driven level
	// ------------------------------------------------------------------
	always @(posedge pclk) begin
		if (sample_word_oe) begin
			bus_last  <= sample_word;
			flag_last <= overflow_flag;
		end
	end
	assign word_pins = sample_word_oe ? sample_word : ~bus_last;
	assign flag_pin  = overflow_flag_oe ? overflow_flag : ~flag_last;

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task check(input string what, input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Output enable changes only between long phases
	task ctrl(input logic [3:0] v);
		apb(1'b1, `AFC_ADDR_CTRL, {28'h0000000, v});
		repeat (2) @(posedge pclk);
		#1;
	endtask : ctrl

	task sample(input logic [11:0] s, input logic o, input logic u);
		@(posedge pclk);
		core_strobe <= 1'b1;
		core_sample <= s;
		core_over   <= o;
		core_under  <= u;
		@(posedge pclk);
		core_strobe <= 1'b0;
		core_over   <= 1'b0;
		core_under  <= 1'b0;
		#1;
	endtask : sample

	// Strobes every cycle until samples are trustworthy again
	task wait_valid(input string what, input int lo, input int hi);
		int n;
		n = 0;
		while (data_valid !== 1'b1 && n <= hi) begin
			@(posedge pclk);
			core_strobe <= 1'b1;
			n++;
			#1;
		end
		@(posedge pclk);
		core_strobe <= 1'b0;
		check(what, (n >= lo && n <= hi), 1);
	endtask : wait_valid

	initial begin
		repeat (6000) @(posedge pclk);
		bad_count++;
		complete_run();
	end

	initial begin
		{presetn, psel, penable, pwrite, core_strobe, core_over, core_under} = '0;
		{paddr, core_sample, pwdata, bad_count, tests_run, n_ovf} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1;
		check("oe_reset", sample_word_oe, 0);
		apb(1'b0, `AFC_ADDR_CTRL, 0);
		check("ctrl_reset", rd, 32'h8);
		// ------------------------------------------------------------------
		// Coding, stabilizer and overflow at every level
		// ------------------------------------------------------------------
		for (int lvl = 0; lvl < 4; lvl++) begin
			ctrl({2'b00, lvl[1:0]});
			check("dcs", dcs_enable, (lvl == 1 || lvl == 2));
			if (lvl == 1) begin
				wait_valid("relock", RLK_N - 4, RLK_N + 6);
			end
			if (lvl == 2) begin
				// Sample clock stopped long enough to lose lock, then restarted
				repeat (`AFC_CLK_STOP_CYC + 6) @(posedge pclk);
				sample(12'h123, 1'b0, 1'b0);
				check("stop_drop", data_valid, 0);
				wait_valid("stop_relock", RLK_N - 4, RLK_N + 6);
			end
			for (int k = 0; k < 3; k++) begin
				sample(12'h123, k == 1, k == 2);
				n_ovf += (k > 0);
				exp = (k == 1) ? 12'hFFF : (k == 2) ? 12'h000 : 12'h123;
				if (lvl >= 2) begin
					exp[11] = ~exp[11];
				end
				check("word", sample_word, exp);
				check("flag", overflow_flag, k > 0);
				check("strobe", sample_strobe, 1);
			end
		end
		ctrl(4'h0);
		sample(12'h5A5, 1'b0, 1'b0);
		@(posedge pclk);
		#1;
		check("capture", last_cap, 13'h05A5);
		// ------------------------------------------------------------------
		// Output disable, nap and sleep
		// ------------------------------------------------------------------
		ctrl(4'h8);
		taken_mark = taken;
		sample(12'h321, 1'b0, 1'b0);
		check("hiz_word", sample_word, 12'h321);
		check("hiz_oe", {sample_word_oe, overflow_flag_oe}, 0);
		check("hiz_mode", power_mode, PWR_NORMAL);
		ctrl(4'h4);
		check("nap_mode", power_mode, PWR_NAP);
		check("nap_oe", {sample_word_oe, overflow_flag_oe}, 0);
		sample(12'hABC, 1'b1, 1'b0);
		check("nap_hold", sample_word, 12'h321);
		check("nap_taken", taken, taken_mark);
		apb(1'b0, `AFC_ADDR_STATUS, 0);
		check("nap_stat", rd[1:0], 2'd1);
		ctrl(4'h0);
		wait_valid("nap_rec", NAP_N - 4, NAP_N + 4);
		apb(1'b0, `AFC_ADDR_STATUS, 0);
		check("run_stat", rd, (1 << `AFC_STAT_DRIVE) | (1 << `AFC_STAT_VALID) | (1 << `AFC_STAT_LOCKED));
		ctrl(4'hC);
		check("slp_mode", power_mode, PWR_SLEEP);
		check("slp_oe", {sample_word_oe, overflow_flag_oe}, 0);
		check("slp_valid", data_valid, 0);
		ctrl(4'h0);
		wait_valid("slp_rec", SLEEP_N - 4, SLEEP_N + 6);
		// ------------------------------------------------------------------
		// Overflow count and an unmapped address
		// ------------------------------------------------------------------
		apb(1'b0, `AFC_ADDR_OVF_COUNT, 0);
		check("ovf_cnt", rd, n_ovf);
		apb(1'b1, `AFC_ADDR_OVF_COUNT, 0);
		apb(1'b0, `AFC_ADDR_OVF_COUNT, 0);
		check("ovf_clr", rd, 0);
		apb(1'b0, 12'h00C, 0);
		check("bad_err", err, 1);
		check("bad_data", rd, 0);
		complete_run();
	end
endmodule : afc_ctrl_test

`default_nettype wire
